// ===== crsf_pkg.sv
// Constants and types of the CPU register set with its flag logic.
// Assumes one 25 MHz clock and a synchronous active-low reset.
// Behaviour
// - Eight alike 32-bit general registers, read or written as 32, 16 or 8 bits.
// - Each general register splits into upper and lower 16-bit halves.
// - Each lower half splits into a high byte and a low byte.
// - Program counter is 24 bits; its lowest bit reads as zero on fetch.
// - Trace bit 7 of extend_control set requests a trace after each instruction.
// - Extend_control bits 2..0 hold mask level 0..7; bits 6..3 reserved.
// - Load, and, or, xor to extend_control block all interrupts for 3 states.
// - Flag bit 7 set masks all interrupts except the non-maskable one.
// - Flag bit 7 is set at the start of every exception sequence.
// - Flag bit 6 is a plain readable, writable user bit, no masking effect.
// - Half-carry is the carry or borrow out of bit 3, 11 or 27.
// - Flag bit 4 is a general user bit with no other effect.
// - Negative flag bit 3 copies the sign bit of the result.
// - Zero flag bit 2 is one exactly when the result is zero.
// - Overflow flag bit 1 is one exactly on arithmetic overflow.
// - Carry bit 0 holds add carry, subtract borrow, or shifted-out bit.
// - Carry bit also serves as the one-bit accumulator of bit operations.
// - Bit operations pick bit 0..7 of a byte; 1, 4, 8, 16, 32-bit data.
// - Decimal adjust views a byte as two packed 4-bit digits.
// - Normal mode spans 64 kbytes, advanced mode 16 Mbytes.
// - Normal mode drops the upper 8 bits of each effective address.

package crsf_pkg;

  localparam int GPR_COUNT = 8;
  localparam logic [31:0] GPR_RESET = 32'h00000000;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [23:0] NORMAL_EA_MASK = 24'h00ffff;
  localparam logic [7:0] EXR_RESET = 8'h07;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [3:0] EXR_RSVD_READ = 4'h0;
  localparam int INT_BLOCK_STATES = 3;

  localparam int EXR_TRACE_BIT = 7;
  localparam int EXR_MASK_MSB = 2;
  localparam int CCR_I_BIT = 7;
  localparam int CCR_UI_BIT = 6;
  localparam int CCR_H_BIT = 5;
  localparam int CCR_U_BIT = 4;
  localparam int CCR_N_BIT = 3;
  localparam int CCR_Z_BIT = 2;
  localparam int CCR_V_BIT = 1;
  localparam int CCR_C_BIT = 0;

  localparam int MSB_BYTE = 7;
  localparam int MSB_WORD = 15;
  localparam int MSB_LONG = 31;
  localparam int HALF_BYTE_BIT = 3;
  localparam int HALF_WORD_BIT = 11;
  localparam int HALF_LONG_BIT = 27;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } crsf_size_type;

  typedef enum logic [2:0] {
    CTRL_LOAD = 3'h0,
    CTRL_STORE = 3'h1,
    CTRL_AND = 3'h2,
    CTRL_OR = 3'h3,
    CTRL_XOR = 3'h4
  } crsf_ctrlop_type;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0,
    ALU_SUB = 4'h1,
    ALU_CMP = 4'h2,
    ALU_NEG = 4'h3,
    ALU_MOVE = 4'h4,
    ALU_SHL = 4'h5,
    ALU_SHR = 4'h6,
    ALU_BLD = 4'h7,
    ALU_BST = 4'h8,
    ALU_BAND = 4'h9,
    ALU_BOR = 4'ha,
    ALU_BXOR = 4'hb
  } crsf_aluop_type;

  // Gray sequence, one step per blocked state
  typedef enum logic [1:0] {
    BLK_IDLE = 2'h0,
    BLK_ONE = 2'h1,
    BLK_TWO = 2'h3,
    BLK_THREE = 2'h2
  } crsf_block_type;

endpackage

// ===== cpu_register_set_flags.sv
// Programmer-visible register set: general registers, program counter,
// extend_control and flag_register with flag update and interrupt gating.
// Assumes decode and sequencing logic outside drive the request ports on
// the same clock; only the mode pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none

module cpu_register_set_flags (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic modePin,
  input wire logic wrEn,
  input wire logic [3:0] wrSel,
  input wire crsf_pkg::crsf_size_type wrSize,
  input wire logic [31:0] wrData,
  input wire logic [3:0] rdSel,
  input wire crsf_pkg::crsf_size_type rdSize,
  output logic [31:0] rdData,
  output logic [3:0] bcdHigh,
  output logic [3:0] bcdLow,
  input wire logic aluGo,
  input wire crsf_pkg::crsf_aluop_type aluOp,
  input wire logic [3:0] aluSel,
  input wire crsf_pkg::crsf_size_type aluSize,
  input wire logic [31:0] aluSrc,
  input wire logic [2:0] bitSel,
  input wire logic ctrlGo,
  input wire crsf_pkg::crsf_ctrlop_type ctrlOp,
  input wire logic ctrlToExtend,
  input wire logic [7:0] ctrlData,
  output logic [7:0] ctrlRdData,
  input wire logic pcLoad,
  input wire logic [23:0] pcLoadValue,
  input wire logic pcStep,
  output logic [23:0] pcValue,
  output logic [23:0] fetchAddr,
  input wire logic instrDone,
  output logic traceReq,
  input wire logic excStart,
  input wire logic nmiReq,
  input wire logic irqReq,
  input wire logic [2:0] irqLevel,
  output logic irqAccept,
  output logic intBlocked,
  input wire logic [23:0] eaIn,
  output logic [23:0] eaOut,
  output logic advancedMode,
  output logic [7:0] flagsOut,
  output logic [7:0] extendOut
);

  typedef struct packed {
    logic [7:0][31:0] gpr;
    logic [23:0] pc;
    logic trace;
    logic [2:0] mask;
    logic [7:0] flag_register;
    crsf_pkg::crsf_block_type blk;
    logic [31:0] rdData;
    logic [7:0] ctrlRd;
    logic traceReq;
    logic [23:0] ea;
    logic [1:0] modeSync;
    logic advanced;
  } crsf_state_type;

  crsf_state_type s_r;
  crsf_state_type s_nxt;

  function automatic int crsfMsb(input crsf_pkg::crsf_size_type sz);
    case (sz)
      crsf_pkg::SIZE_BYTE: return crsf_pkg::MSB_BYTE;
      crsf_pkg::SIZE_WORD: return crsf_pkg::MSB_WORD;
      default: return crsf_pkg::MSB_LONG;
    endcase
  endfunction

  function automatic logic [31:0] crsfMask(input crsf_pkg::crsf_size_type sz);
    case (sz)
      crsf_pkg::SIZE_BYTE: return 32'h000000ff;
      crsf_pkg::SIZE_WORD: return 32'h0000ffff;
      default: return 32'hffffffff;
    endcase
  endfunction

  // Sel bit 3: upper word for words, low byte for bytes
  function automatic logic [31:0] crsfView(input logic [31:0] full,
                                           input logic sel3,
                                           input crsf_pkg::crsf_size_type sz);
    case (sz)
      crsf_pkg::SIZE_BYTE:
        return sel3 ? {24'h000000, full[7:0]} : {24'h000000, full[15:8]};
      crsf_pkg::SIZE_WORD:
        return sel3 ? {16'h0000, full[31:16]} : {16'h0000, full[15:0]};
      default: return full;
    endcase
  endfunction

  function automatic logic [31:0] crsfMerge(input logic [31:0] full,
                                            input logic [31:0] d,
                                            input logic sel3,
                                            input crsf_pkg::crsf_size_type sz);
    case (sz)
      crsf_pkg::SIZE_BYTE:
        return sel3 ? {full[31:8], d[7:0]}
                    : {full[31:16], d[7:0], full[7:0]};
      crsf_pkg::SIZE_WORD:
        return sel3 ? {d[15:0], full[15:0]} : {full[31:16], d[15:0]};
      default: return d;
    endcase
  endfunction

  // Returns {carry, half, overflow, result}; carry is borrow when sub
  function automatic logic [34:0] crsfAddSub(input logic [31:0] a,
                                             input logic [31:0] b,
                                             input logic sub,
                                             input crsf_pkg::crsf_size_type sz);
    logic [31:0] bx;
    logic [32:0] sum;
    logic [32:0] cv;
    int m;
    int hp;
    bx = sub ? ~b : b;
    sum = {1'b0, a} + {1'b0, bx} + {32'h00000000, sub};
    cv = {1'b0, a} ^ {1'b0, bx} ^ sum;
    m = crsfMsb(sz);
    case (sz)
      crsf_pkg::SIZE_BYTE: hp = crsf_pkg::HALF_BYTE_BIT;
      crsf_pkg::SIZE_WORD: hp = crsf_pkg::HALF_WORD_BIT;
      default: hp = crsf_pkg::HALF_LONG_BIT;
    endcase
    return {cv[m + 1] ^ sub, cv[hp + 1] ^ sub, cv[m] ^ cv[m + 1],
            sum[31:0] & crsfMask(sz)};
  endfunction

  logic [31:0] dstView;
  logic [31:0] byteView;
  logic [31:0] aluRes;
  logic [34:0] arith;
  logic aluWr;
  logic setNz;
  logic bitVal;
  logic [7:0] flg;
  logic [7:0] ctrlCur;
  logic [7:0] ctrlNew;
  logic blockNow;
  logic [23:0] addrMask;

  always_comb begin
    s_nxt = s_r;
    dstView = crsfView(s_r.gpr[aluSel[2:0]], aluSel[3], aluSize);
    byteView = crsfView(s_r.gpr[aluSel[2:0]], aluSel[3],
                        crsf_pkg::SIZE_BYTE);
    bitVal = byteView[bitSel];
    aluRes = dstView;
    arith = {35{1'b0}};
    aluWr = 1'b0;
    setNz = 1'b0;
    flg = s_r.flag_register;
    ctrlCur = 8'h00;
    ctrlNew = 8'h00;
    s_nxt.modeSync = {s_r.modeSync[0], modePin};
    s_nxt.traceReq = 1'b0;
    if (!rst_n) begin
      s_nxt.gpr = {crsf_pkg::GPR_COUNT{crsf_pkg::GPR_RESET}};
      s_nxt.pc = crsf_pkg::PC_RESET;
      s_nxt.trace = crsf_pkg::EXR_RESET[crsf_pkg::EXR_TRACE_BIT];
      s_nxt.mask = crsf_pkg::EXR_RESET[crsf_pkg::EXR_MASK_MSB:0];
      s_nxt.flag_register = crsf_pkg::CCR_RESET;
      s_nxt.blk = crsf_pkg::BLK_IDLE;
      s_nxt.rdData = 32'h00000000;
      s_nxt.ctrlRd = 8'h00;
      s_nxt.ea = 24'h000000;
      // Mode is a strap: held steady from reset release on
      s_nxt.advanced = s_r.modeSync[1];
    end else begin
      // Read returns the value before any write in the same cycle
      s_nxt.rdData = crsfView(s_r.gpr[rdSel[2:0]], rdSel[3], rdSize);
      if (wrEn) begin
        s_nxt.gpr[wrSel[2:0]] = crsfMerge(s_r.gpr[wrSel[2:0]], wrData,
                                          wrSel[3], wrSize);
      end
      if (aluGo) begin
        case (aluOp)
          crsf_pkg::ALU_ADD, crsf_pkg::ALU_SUB, crsf_pkg::ALU_CMP,
          crsf_pkg::ALU_NEG: begin
            if (aluOp == crsf_pkg::ALU_NEG) begin
              arith = crsfAddSub(32'h00000000, dstView, 1'b1, aluSize);
            end else begin
              arith = crsfAddSub(dstView, aluSrc & crsfMask(aluSize),
                                 aluOp != crsf_pkg::ALU_ADD, aluSize);
            end
            aluRes = arith[31:0];
            flg[crsf_pkg::CCR_H_BIT] = arith[33];
            flg[crsf_pkg::CCR_V_BIT] = arith[32];
            flg[crsf_pkg::CCR_C_BIT] = arith[34];
            aluWr = aluOp != crsf_pkg::ALU_CMP;
            setNz = 1'b1;
          end
          crsf_pkg::ALU_MOVE: begin
            aluRes = aluSrc & crsfMask(aluSize);
            flg[crsf_pkg::CCR_V_BIT] = 1'b0;
            aluWr = 1'b1;
            setNz = 1'b1;
          end
          crsf_pkg::ALU_SHL: begin
            aluRes = (dstView << 1) & crsfMask(aluSize);
            flg[crsf_pkg::CCR_C_BIT] = dstView[crsfMsb(aluSize)];
            flg[crsf_pkg::CCR_V_BIT] = 1'b0;
            aluWr = 1'b1;
            setNz = 1'b1;
          end
          crsf_pkg::ALU_SHR: begin
            aluRes = dstView >> 1;
            flg[crsf_pkg::CCR_C_BIT] = dstView[0];
            flg[crsf_pkg::CCR_V_BIT] = 1'b0;
            aluWr = 1'b1;
            setNz = 1'b1;
          end
          crsf_pkg::ALU_BLD: begin
            flg[crsf_pkg::CCR_C_BIT] = bitVal;
          end
          crsf_pkg::ALU_BST: begin
            aluRes = byteView;
            aluRes[bitSel] = s_r.flag_register[crsf_pkg::CCR_C_BIT];
            s_nxt.gpr[aluSel[2:0]] = crsfMerge(s_nxt.gpr[aluSel[2:0]],
                                               aluRes, aluSel[3],
                                               crsf_pkg::SIZE_BYTE);
          end
          crsf_pkg::ALU_BAND: begin
            flg[crsf_pkg::CCR_C_BIT] = s_r.flag_register[crsf_pkg::CCR_C_BIT] & bitVal;
          end
          crsf_pkg::ALU_BOR: begin
            flg[crsf_pkg::CCR_C_BIT] = s_r.flag_register[crsf_pkg::CCR_C_BIT] | bitVal;
          end
          crsf_pkg::ALU_BXOR: begin
            flg[crsf_pkg::CCR_C_BIT] = s_r.flag_register[crsf_pkg::CCR_C_BIT] ^ bitVal;
          end
          default: begin
            aluWr = 1'b0;
          end
        endcase
        if (setNz) begin
          flg[crsf_pkg::CCR_N_BIT] = aluRes[crsfMsb(aluSize)];
          flg[crsf_pkg::CCR_Z_BIT] = aluRes == 32'h00000000;
        end
        if (aluWr) begin
          // ALU result lands after a same-cycle direct write
          s_nxt.gpr[aluSel[2:0]] = crsfMerge(s_nxt.gpr[aluSel[2:0]],
                                             aluRes, aluSel[3], aluSize);
        end
      end
      s_nxt.flag_register = flg;
      if (ctrlGo) begin
        ctrlCur = ctrlToExtend
                ? {s_r.trace, crsf_pkg::EXR_RSVD_READ, s_r.mask}
                : s_r.flag_register;
        case (ctrlOp)
          crsf_pkg::CTRL_LOAD: ctrlNew = ctrlData;
          crsf_pkg::CTRL_AND: ctrlNew = ctrlCur & ctrlData;
          crsf_pkg::CTRL_OR: ctrlNew = ctrlCur | ctrlData;
          crsf_pkg::CTRL_XOR: ctrlNew = ctrlCur ^ ctrlData;
          default: ctrlNew = ctrlCur;
        endcase
        if (ctrlOp == crsf_pkg::CTRL_STORE) begin
          s_nxt.ctrlRd = ctrlCur;
        end else if (ctrlToExtend) begin
          // Reserved bits are dropped on write
          s_nxt.trace = ctrlNew[crsf_pkg::EXR_TRACE_BIT];
          s_nxt.mask = ctrlNew[crsf_pkg::EXR_MASK_MSB:0];
        end else begin
          // All eight bits, user bits 6 and 4 included, are plain storage
          s_nxt.flag_register = ctrlNew;
        end
      end
      // Exception entry wins over any same-cycle clear of the mask bit
      if (excStart) begin
        s_nxt.flag_register[crsf_pkg::CCR_I_BIT] = 1'b1;
      end
      case (s_r.blk)
        crsf_pkg::BLK_ONE: s_nxt.blk = crsf_pkg::BLK_TWO;
        crsf_pkg::BLK_TWO: s_nxt.blk = crsf_pkg::BLK_THREE;
        default: s_nxt.blk = crsf_pkg::BLK_IDLE;
      endcase
      if (ctrlGo && ctrlToExtend && ctrlOp != crsf_pkg::CTRL_STORE) begin
        s_nxt.blk = crsf_pkg::BLK_ONE;
      end
      if (pcLoad) begin
        s_nxt.pc = pcLoadValue;
      end else if (pcStep) begin
        s_nxt.pc = s_r.pc + crsf_pkg::PC_STEP;
      end
      s_nxt.traceReq = instrDone & s_r.trace;
      s_nxt.ea = eaIn & addrMask;
    end
  end

  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  // Normal mode keeps fetches inside 64 kbytes as well
  assign addrMask = s_r.advanced ? 24'hffffff : crsf_pkg::NORMAL_EA_MASK;
  assign fetchAddr = {s_r.pc[23:1] & addrMask[23:1], 1'b0};
  assign pcValue = s_r.pc;
  assign eaOut = s_r.ea;
  assign advancedMode = s_r.advanced;

  // Blocking also covers the cycle of the control write itself
  assign blockNow = (s_r.blk != crsf_pkg::BLK_IDLE)
                 || (ctrlGo && ctrlToExtend
                     && ctrlOp != crsf_pkg::CTRL_STORE);
  assign intBlocked = blockNow;
  assign irqAccept = rst_n && !blockNow
                  && (nmiReq
                      || (irqReq && !s_r.flag_register[crsf_pkg::CCR_I_BIT]
                          && irqLevel > s_r.mask));

  assign rdData = s_r.rdData;
  assign bcdHigh = s_r.rdData[7:4];
  assign bcdLow = s_r.rdData[3:0];
  assign ctrlRdData = s_r.ctrlRd;
  assign traceReq = s_r.traceReq;
  assign flagsOut = s_r.flag_register;
  assign extendOut = {s_r.trace, crsf_pkg::EXR_RSVD_READ, s_r.mask};

endmodule

`default_nettype wire

// ===== crsf_handover_end.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== crsf_monitor.sv
// Checker for the register set: gating, trace, flags and address views.
// Assumes binding into cpu_register_set_flags; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none

module crsf_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic instrDone,
  input wire logic traceReq,
  input wire logic [7:0] extendOut,
  input wire logic [7:0] flagsOut,
  input wire logic ctrlGo,
  input wire logic ctrlToExtend,
  input wire crsf_pkg::crsf_ctrlop_type ctrlOp,
  input wire logic [7:0] ctrlData,
  input wire logic intBlocked,
  input wire logic irqAccept,
  input wire logic nmiReq,
  input wire logic excStart,
  input wire logic [23:0] pcValue,
  input wire logic [23:0] fetchAddr,
  input wire logic advancedMode,
  input wire logic [23:0] eaIn,
  input wire logic [23:0] eaOut
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  trace_pulse_a: assert property (
    instrDone && extendOut[7] |=> traceReq)
    else $error("no trace request after instruction");
  block_window_a: assert property (
    ctrlGo && ctrlToExtend && ctrlOp != crsf_pkg::CTRL_STORE
    |-> intBlocked [*4])
    else $error("interrupt block window too short");
  block_gate_a: assert property (
    intBlocked |-> !irqAccept)
    else $error("interrupt accepted while blocked");
  nmi_accept_a: assert property (
    nmiReq && !intBlocked |-> irqAccept)
    else $error("non-maskable request refused");
  mask_bit_a: assert property (
    flagsOut[7] && !nmiReq |-> !irqAccept)
    else $error("maskable request passed the mask bit");
  exc_mask_a: assert property (
    excStart |=> flagsOut[7])
    else $error("mask bit not set by exception start");
  fetch_view_a: assert property (
    fetchAddr == {advancedMode ? pcValue[23:16] : 8'h00,
                  pcValue[15:1], 1'b0})
    else $error("fetch address view wrong");
  ea_width_a: assert property (
    rst_n |=> eaOut == ($past(advancedMode) ? $past(eaIn) :
                        {8'h00, $past(eaIn[15:0])}))
    else $error("effective address width wrong");
  load_extend_a: assert property (
    ctrlGo && ctrlToExtend && ctrlOp == crsf_pkg::CTRL_LOAD
    |=> extendOut == ($past(ctrlData) & 8'h87))
    else $error("extend load did not keep reserved bits clear");

  cover property (traceReq);
  cover property (intBlocked ##1 !intBlocked);
  cover property (irqAccept && !nmiReq);
endmodule

bind cpu_register_set_flags crsf_monitor u_mon (
  .clock(clock), .rst_n(rst_n), .instrDone(instrDone),
  .traceReq(traceReq), .extendOut(extendOut), .flagsOut(flagsOut),
  .ctrlGo(ctrlGo), .ctrlToExtend(ctrlToExtend), .ctrlOp(ctrlOp),
  .ctrlData(ctrlData), .intBlocked(intBlocked), .irqAccept(irqAccept),
  .nmiReq(nmiReq), .excStart(excStart), .pcValue(pcValue),
  .fetchAddr(fetchAddr), .advancedMode(advancedMode), .eaIn(eaIn),
  .eaOut(eaOut));
`default_nettype wire

// ===== crsf_testbench.sv
// Self-checking bench: behavioural register and flag model vs the design.
// Assumes crsf_pkg, the design and crsf_monitor are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clock, rst_n, modePin, wrEn, aluGo, ctrlGo, ctrlToExtend, pcLoad;
  logic pcStep, instrDone, excStart, nmiReq, irqReq, traceReq, irqAccept;
  logic intBlocked, advancedMode;
  logic [3:0] wrSel, rdSel, aluSel, bcdHigh, bcdLow;
  logic [2:0] bitSel, irqLevel;
  logic [31:0] wrData, aluSrc, rdData;
  logic [7:0] ctrlData, ctrlRdData, flagsOut, extendOut, mf, mx, mr;
  logic [23:0] pcLoadValue, pcValue, fetchAddr, eaIn, eaOut;
  crsf_pkg::crsf_size_type wrSize, rdSize, aluSize;
  crsf_pkg::crsf_aluop_type aluOp;
  crsf_pkg::crsf_ctrlop_type ctrlOp;
  logic [31:0] mg [8];
  int error_cnt = 0;
  int tests_run = 0;

  cpu_register_set_flags DUT (.clock(clock), .rst_n(rst_n),
    .modePin(modePin), .wrEn(wrEn), .wrSel(wrSel), .wrSize(wrSize),
    .wrData(wrData), .rdSel(rdSel), .rdSize(rdSize), .rdData(rdData),
    .bcdHigh(bcdHigh), .bcdLow(bcdLow), .aluGo(aluGo), .aluOp(aluOp),
    .aluSel(aluSel), .aluSize(aluSize), .aluSrc(aluSrc), .bitSel(bitSel),
    .ctrlGo(ctrlGo), .ctrlOp(ctrlOp), .ctrlToExtend(ctrlToExtend),
    .ctrlData(ctrlData), .ctrlRdData(ctrlRdData), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .pcStep(pcStep), .pcValue(pcValue),
    .fetchAddr(fetchAddr), .instrDone(instrDone), .traceReq(traceReq),
    .excStart(excStart), .nmiReq(nmiReq), .irqReq(irqReq),
    .irqLevel(irqLevel), .irqAccept(irqAccept), .intBlocked(intBlocked),
    .eaIn(eaIn), .eaOut(eaOut), .advancedMode(advancedMode),
    .flagsOut(flagsOut), .extendOut(extendOut));

  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] vget(logic [3:0] s,
                                       crsf_pkg::crsf_size_type z);
    logic [31:0] g;
    g = mg[s[2:0]];
    if (z == crsf_pkg::SIZE_LONG) return g;
    if (z == crsf_pkg::SIZE_WORD) return s[3] ? g[31:16] : g[15:0];
    return s[3] ? g[7:0] : g[15:8];
  endfunction

  task automatic vset(logic [3:0] s, crsf_pkg::crsf_size_type z,
                      logic [31:0] d);
    if (z == crsf_pkg::SIZE_LONG) mg[s[2:0]] = d;
    else if (z == crsf_pkg::SIZE_WORD && s[3]) mg[s[2:0]][31:16] = d[15:0];
    else if (z == crsf_pkg::SIZE_WORD) mg[s[2:0]][15:0] = d[15:0];
    else if (s[3]) mg[s[2:0]][7:0] = d[7:0];
    else mg[s[2:0]][15:8] = d[7:0];
  endtask

  task automatic rdchk(logic [3:0] s, crsf_pkg::crsf_size_type z);
    rdSel = s;
    rdSize = z;
    step();
    chk("rdData", rdData, vget(s, z));
    chk("bcd", {bcdHigh, bcdLow}, vget(s, z) & 32'hff);
  endtask

  task automatic rs(logic md);
    modePin = md;
    rst_n = 0;
    repeat (5) step();
    rst_n = 1;
    foreach (mg[i]) mg[i] = crsf_pkg::GPR_RESET;
    mf = crsf_pkg::CCR_RESET;
    mx = crsf_pkg::EXR_RESET;
    mr = 8'h00;
    chk("flagsOut", flagsOut, mf);
    chk("extendOut", extendOut, mx);
    chk("advancedMode", advancedMode, md);
  endtask

  task automatic pcea();
    pcLoad = 1;
    pcLoadValue = 24'($urandom) | 24'h000001;
    step();
    pcLoad = 0;
    pcStep = 1;
    chk("pcValue", pcValue, pcLoadValue);
    chk("fetchAddr", fetchAddr, (modePin ? pcLoadValue : pcLoadValue & 24'h00ffff) & 24'hfffffe);
    step();
    pcStep = 0;
    eaIn = 24'($urandom);
    chk("pcValue", pcValue, pcLoadValue + 24'h000002);
    step();
    chk("eaOut", eaOut, modePin ? eaIn : eaIn & 24'h00ffff);
  endtask

  task automatic alu(int oi, logic [3:0] s, crsf_pkg::crsf_size_type z,
                     logic [31:0] src, logic [2:0] b);
    longint a, c, r, t, m, hm;
    int w, h;
    aluGo = 1;
    aluOp = crsf_pkg::crsf_aluop_type'(oi);
    aluSel = s;
    aluSize = z;
    aluSrc = src;
    bitSel = b;
    step();
    aluGo = 0;
    w = (z == crsf_pkg::SIZE_BYTE) ? 8 : (z == crsf_pkg::SIZE_WORD) ? 16 : 32;
    h = w - 5;
    m = (64'd1 << w) - 1;
    hm = (64'd1 << (h + 1)) - 1;
    a = vget(s, z);
    c = src & m;
    if (oi == 3) begin
      c = a;
      a = 0;
    end
    r = (oi == 4) ? c : (oi == 0) ? a + c : a - c;
    t = (oi == 0) ? (a & hm) + (c & hm) : (a & hm) - (c & hm);
    // Borrow shows as the bit above the field, same as carry
    if (oi < 4) begin
      mf[0] = r[w];
      mf[5] = t[h + 1];
      mf[1] = (a[w-1] != r[w-1]) && ((a[w-1] == c[w-1]) == (oi == 0));
    end
    if (oi == 5 || oi == 6) begin
      mf[0] = (oi == 5) ? a[w-1] : a[0];
      r = (oi == 5) ? a << 1 : a >> 1;
    end
    if (oi > 3 && oi < 7) mf[1] = 1'b0;
    if (oi < 7) begin
      mf[3] = r[w-1];
      mf[2] = (r & m) == 0;
      if (oi != 2) vset(s, z, 32'(r));
    end
    if (oi == 7) mf[0] = a[b];
    if (oi == 8) vset(s, z, 32'(mf[0] ? a | (64'd1 << b) : a & ~(64'd1 << b)));
    if (oi == 9) mf[0] &= a[b];
    if (oi == 10) mf[0] |= a[b];
    if (oi == 11) mf[0] ^= a[b];
    chk("flagsOut", flagsOut, mf);
    rdchk(s, z);
  endtask

  task automatic ctl(int o, logic e, logic [7:0] d);
    logic [7:0] v;
    logic blk;
    ctrlGo = 1;
    ctrlOp = crsf_pkg::crsf_ctrlop_type'(o);
    ctrlToExtend = e;
    ctrlData = d;
    blk = e && o != 1;
    v = e ? mx : mf;
    step();
    ctrlGo = 0;
    if (o == 1) mr = v;
    v = (o == 0) ? d : (o == 2) ? v & d : (o == 3) ? v | d : (o == 4) ? v ^ d : v;
    if (e) mx = v & 8'h87;
    else mf = v;
    chk("flagsOut", flagsOut, mf);
    chk("extendOut", extendOut, mx);
    chk("ctrlRdData", ctrlRdData, mr);
    for (int i = 0; i < 4; i++) begin
      {nmiReq, irqReq, irqLevel} = 5'($urandom);
      #1;
      chk("intBlocked", intBlocked, blk && i < 3);
      chk("irqAccept", irqAccept, !(blk && i < 3) && (nmiReq || irqReq && !mf[7] && irqLevel > mx[2:0]));
      step();
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    complete_run();
  end

  initial begin
    logic [3:0] s;
    crsf_pkg::crsf_size_type z;
    {rst_n, modePin, wrEn, aluGo, ctrlGo, ctrlToExtend, pcLoad, pcStep,
     instrDone, excStart, nmiReq, irqReq, wrSel, rdSel, aluSel, bitSel,
     irqLevel, wrData, aluSrc, ctrlData, pcLoadValue, eaIn} = '0;
    wrSize = crsf_pkg::SIZE_BYTE;
    rdSize = crsf_pkg::SIZE_BYTE;
    aluSize = crsf_pkg::SIZE_BYTE;
    aluOp = crsf_pkg::ALU_ADD;
    ctrlOp = crsf_pkg::CTRL_LOAD;
    void'($urandom(32'h9ca9a57a));
    for (int pass = 1; pass >= 0; pass--) begin
      rs(pass[0]);
      for (int k = 0; k < 48; k++) begin
        s = 4'($urandom);
        z = crsf_pkg::crsf_size_type'($urandom % 3);
        wrEn = 1;
        wrSel = s;
        wrSize = z;
        wrData = $urandom;
        vset(s, z, wrData);
        step();
        wrEn = 0;
        rdchk(s, z);
        rdchk(s, crsf_pkg::SIZE_LONG);
      end
      pcea();
      $display("register views done, mode %0d", pass);
    end
    for (int k = 0; k < 72; k++) begin
      s = 4'($urandom);
      z = (k % 12 > 6) ? crsf_pkg::SIZE_BYTE :
          crsf_pkg::crsf_size_type'(k / 12 % 3);
      alu(k % 12, s, z, (k / 12 % 2) ? $urandom : 32'h0 - vget(s, z),
          3'($urandom));
    end
    $display("flag updates done");
    for (int k = 0; k < 30; k++) ctl(k % 5, k / 5 % 2, 8'($urandom));
    ctl(0, 1'b0, 8'h00);
    excStart = 1;
    step();
    excStart = 0;
    mf[7] = 1'b1;
    chk("flagsOut", flagsOut, mf);
    for (int k = 0; k < 2; k++) begin
      ctl(0, 1'b1, k ? 8'h07 : 8'h80);
      instrDone = 1;
      step();
      instrDone = 0;
      chk("traceReq", traceReq, !k);
      step();
      chk("traceReq", traceReq, 1'b0);
    end
    $display("control and interrupt gating done");
    complete_run();
  end
endmodule
`default_nettype wire
